// ===== include/afe_ctl_pkg.sv
/*
 * constants, field layouts and carrier types for the modem front-end
 * pin, clock and power control block.
 * assumes one 50 MHz clock and an APB master with 32-bit data.
 */
package afe_ctl_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL0 = 8'h00;
    localparam logic [7:0] OFF_CTRL1 = 8'h04;
    localparam logic [7:0] OFF_REG2  = 8'h08;
    localparam logic [7:0] OFF_CTRL3 = 8'h0c;

    localparam logic [15:0] CTRL0_RESET = 16'h0300;
    localparam logic [15:0] CTRL1_RESET = 16'h0000;
    localparam logic [15:0] CTRL2_RESET = 16'h0000;
    localparam logic [15:0] CTRL3_RESET = 16'h0000;

    localparam int C0_OVER_LSB   = 3;
    localparam int C0_M_BIT      = 8;
    localparam int C0_Q_BIT      = 9;
    localparam int C1_DIR_LSB    = 0;
    localparam int C1_MASK_LSB   = 4;
    localparam int C1_RMASK_BIT  = 8;
    localparam int C2_OUT_LSB    = 0;
    localparam int C2_GP0CLK_BIT = 6;
    localparam int C2_GP3CLK_BIT = 10;
    localparam int C2_DIV_LSB    = 11;
    localparam int C2_DIV_W      = 5;
    localparam int C3_CL_BIT     = 2;
    localparam int C3_OH_BIT     = 3;
    localparam int C3_PDMODE_BIT = 4;
    localparam int FB_RING_BIT   = 5;
    localparam int FB_LINE_LSB   = 6;
    localparam int FB_SERIAL_BIT = 8;

    localparam logic [2:0]  OVER_C384 = 3'h1;
    localparam logic [2:0]  OVER_C128 = 3'h5;
    localparam logic [2:0]  OVER_C192 = 3'h6;
    localparam logic [2:0]  OVER_C256 = 3'h7;
    localparam logic [12:0] OVER_320  = 13'h0140;
    localparam logic [12:0] OVER_384  = 13'h0180;
    localparam logic [12:0] OVER_128  = 13'h0080;
    localparam logic [12:0] OVER_192  = 13'h00c0;
    localparam logic [12:0] OVER_256  = 13'h0100;
    localparam logic [1:0]  M_LO      = 2'h1;
    localparam logic [1:0]  M_HI      = 2'h2;
    localparam logic [2:0]  Q_LO      = 3'h3;
    localparam logic [2:0]  Q_HI      = 3'h6;
    localparam logic [5:0]  SLOT_BITS = 6'h10;

    localparam int CLK_MHZ        = 50;
    localparam int CLK_PERIOD_NS  = 20;
    localparam int RESUME_TIME_US = 1000;
    localparam int RESUME_CYCLES  = RESUME_TIME_US * CLK_MHZ;
    localparam int RESET_MIN_NS   = 100;
    localparam int RESET_MIN_CYC  = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        LINE_ONHOOK  = 2'b00,
        LINE_OFFHOOK = 2'b01,
        LINE_CALLID  = 2'b10,
        LINE_SPECIAL = 2'b11
    } line_state_t;

    typedef struct packed {
        logic caller_id;
        logic offhook;
    } hook_ctl_t;

    typedef struct packed {
        logic [3:0] val;
        logic [3:0] oe;
    } pin_drive_t;
endpackage

// ===== core/afe_sync2.sv
/*
 * two-flop synchroniser for a bundle of independent levels.
 * assumes each bit is a slow level; bits are not coherent with each other.
 */
`timescale 1ns/1ps
`default_nettype none
module afe_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // levels
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule
`default_nettype wire

// ===== core/afe_gpio_clock_power_control.sv
/*
 * port pins, change interrupt, hook selection, frame sync generation,
 * timeslot choice and the two sleep modes, with an APB register slave.
 * assumes pins, carrier and line-sense levels are asynchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module afe_gpio_clock_power_control #(
    parameter int RESUME_CYCLES = afe_ctl_pkg::RESUME_CYCLES
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // strap and control pins
    input  wire logic        clock_divider_select_i,
    input  wire logic        master_select_i,
    input  wire logic        timeslot_select_i,
    input  wire logic        hook_control_source_i,
    input  wire logic        sleep_n_i,
    // line sense and carrier
    input  wire logic        carrier_clock_i,
    input  wire logic        ring_sense_i,
    input  wire logic        line_in_use_i,
    input  wire logic        loop_limit_i,
    // port pins
    input  wire logic [3:0]  port_pin_i,
    output logic      [3:0]  port_pin_o,
    output logic      [3:0]  port_pin_oe_o,
    // frame sync pin
    input  wire logic        frame_sync_i,
    output logic             frame_sync_o,
    output logic             frame_sync_oe_o,
    // status outputs
    output logic             frame_start_o,
    output logic             slot_second_o,
    output logic [5:0]       slot_first_bit_o,
    output logic             ring_o,
    output logic             general_interrupt_out_o,
    output logic             serial_port_on_o,
    output logic             core_active_o,
    output afe_ctl_pkg::hook_ctl_t hook_o
);
    typedef enum logic [1:0] {PW_RUN, PW_SLEEP, PW_WAKE, PW_RESUME} pw_state_t;

    logic [15:0] ctrl0, ctrl1, ctrl2, ctrl3;
    logic [13:0] sync_out;
    logic [3:0]  pins_s, pins_q;
    logic        carrier_s, carrier_q, ring_src_s, fs_in_s, fs_in_q;
    logic        divsel_s, master_s, ts_s, hooksrc_s, sleep_s;
    logic        ring_next, ring_chg, evt, alive, mode1, rd2, wr;
    logic [3:0]  pin_chg;
    pw_state_t   state;
    logic [$clog2(RESUME_CYCLES+1)-1:0] resume_cnt;
    logic [12:0] fs_cnt, period;
    logic [4:0]  div_cnt, div_n;
    logic        div_clk;
    logic [1:0]  line_code;
    afe_ctl_pkg::pin_drive_t next_drive;

    // every outside level passes two flops first
    afe_sync2 #(.WIDTH(14)) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({port_pin_i, carrier_clock_i,
                   ring_sense_i | line_in_use_i | loop_limit_i, frame_sync_i,
                   clock_divider_select_i, master_select_i, timeslot_select_i,
                   hook_control_source_i, sleep_n_i, 2'h0}),
        .q_o     (sync_out)
    );
    assign {pins_s, carrier_s, ring_src_s, fs_in_s, divsel_s, master_s,
            ts_s, hooksrc_s, sleep_s} = sync_out[13:2];

    function automatic logic [12:0] over_of(input logic [2:0] code);
        case (code)
            afe_ctl_pkg::OVER_C384: over_of = afe_ctl_pkg::OVER_384;
            afe_ctl_pkg::OVER_C128: over_of = afe_ctl_pkg::OVER_128;
            afe_ctl_pkg::OVER_C192: over_of = afe_ctl_pkg::OVER_192;
            afe_ctl_pkg::OVER_C256: over_of = afe_ctl_pkg::OVER_256;
            default:                over_of = afe_ctl_pkg::OVER_320;
        endcase
    endfunction

    // apb: zero-wait access phase, read data caught in setup
    assign pready = penable;
    assign wr     = psel && penable && pwrite;
    assign rd2    = psel && penable && !pwrite && paddr == afe_ctl_pkg::OFF_REG2;
    assign mode1  = ctrl3[afe_ctl_pkg::C3_PDMODE_BIT];

    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            pslverr = !(paddr == afe_ctl_pkg::OFF_CTRL0 || paddr == afe_ctl_pkg::OFF_CTRL1
                     || paddr == afe_ctl_pkg::OFF_REG2 || paddr == afe_ctl_pkg::OFF_CTRL3);
        end
    end

    // registers survive sleep; only reset clears them
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl0 <= afe_ctl_pkg::CTRL0_RESET;
            ctrl1 <= afe_ctl_pkg::CTRL1_RESET;
            ctrl2 <= afe_ctl_pkg::CTRL2_RESET;
            ctrl3 <= afe_ctl_pkg::CTRL3_RESET;
        end else if (wr) begin
            case (paddr)
                afe_ctl_pkg::OFF_CTRL0: ctrl0 <= pwdata[15:0];
                afe_ctl_pkg::OFF_CTRL1: ctrl1 <= pwdata[15:0];
                afe_ctl_pkg::OFF_REG2:  ctrl2 <= pwdata[15:0];
                afe_ctl_pkg::OFF_CTRL3: ctrl3 <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            case (paddr)
                afe_ctl_pkg::OFF_CTRL0: prdata <= {16'h0, ctrl0};
                afe_ctl_pkg::OFF_CTRL1: prdata <= {16'h0, ctrl1};
                afe_ctl_pkg::OFF_REG2:  prdata <= {23'h0, serial_port_on_o, line_code, ring_o,
                                                   1'b0, pins_q};
                afe_ctl_pkg::OFF_CTRL3: prdata <= {16'h0, ctrl3};
                default:                prdata <= 32'h0;
            endcase
        end
    end

    // power sequencing
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state      <= PW_RUN;
            resume_cnt <= '0;
        end else begin
            case (state)
                PW_RUN: begin
                    if (!sleep_s) state <= PW_SLEEP;
                end
                PW_SLEEP: begin
                    resume_cnt <= '0;
                    if (sleep_s) begin
                        state <= PW_RESUME;
                    end else if (mode1 && evt) begin
                        state <= PW_WAKE;
                    end
                end
                PW_WAKE: begin
                    resume_cnt <= '0;
                    if (sleep_s) begin
                        state <= PW_RESUME;
                    end else if (rd2) begin
                        state <= PW_SLEEP;
                    end
                end
                PW_RESUME: begin
                    resume_cnt <= resume_cnt + 1'b1;
                    if (!sleep_s) begin
                        state <= PW_SLEEP;
                    end else if (resume_cnt == ($bits(resume_cnt))'(RESUME_CYCLES - 1)) begin
                        state <= PW_RUN;
                    end
                end
                default: state <= PW_RUN;
            endcase
        end
    end

    // mode 0 sleep kills ring and change logic; mode 1 keeps them
    assign alive = !(state == PW_SLEEP && !mode1);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_port_on_o <= 1'b1;
            core_active_o    <= 1'b1;
        end else begin
            // masked mode 1 never leaves sleep without the pin
            serial_port_on_o <= state == PW_RUN || state == PW_WAKE;
            core_active_o    <= state == PW_RUN;
        end
    end

    // ring output and change interrupt
    assign ring_next = alive && ring_src_s;
    assign pin_chg   = (pins_s ^ pins_q) & ~port_pin_oe_o
                       & ~ctrl1[afe_ctl_pkg::C1_MASK_LSB +: 4];
    assign ring_chg  = (ring_next ^ ring_o) && !ctrl1[afe_ctl_pkg::C1_RMASK_BIT];
    assign evt       = alive && ((|pin_chg) || ring_chg);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pins_q                  <= 4'h0;
            ring_o                  <= 1'b0;
            general_interrupt_out_o <= 1'b0;
        end else begin
            pins_q <= pins_s;
            ring_o <= ring_next;
            if (evt) general_interrupt_out_o <= !general_interrupt_out_o;
        end
    end

    // line state source and hook outputs
    always_comb begin
        if (hooksrc_s) begin
            line_code = {pins_s[1], pins_s[2]};
        end else begin
            line_code = {ctrl3[afe_ctl_pkg::C3_CL_BIT], ctrl3[afe_ctl_pkg::C3_OH_BIT]};
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hook_o <= '0;
        end else if (line_code != afe_ctl_pkg::LINE_SPECIAL) begin
            // special code holds the last state
            hook_o.offhook   <= line_code == afe_ctl_pkg::LINE_OFFHOOK;
            hook_o.caller_id <= line_code == afe_ctl_pkg::LINE_CALLID;
        end
    end

    // carrier divided by N; both edges counted so the period is N carrier cycles
    assign div_n = ctrl2[afe_ctl_pkg::C2_DIV_LSB +: afe_ctl_pkg::C2_DIV_W];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            carrier_q <= 1'b0;
            div_cnt   <= 5'h0;
            div_clk   <= 1'b0;
        end else begin
            carrier_q <= carrier_s;
            if (carrier_s != carrier_q) begin
                if (div_cnt + 5'h1 >= div_n) begin
                    div_cnt <= 5'h0;
                    div_clk <= !div_clk;
                end else begin
                    div_cnt <= div_cnt + 5'h1;
                end
            end
        end
    end

    // pin drivers; hook source pins forced to inputs
    always_comb begin
        next_drive.oe  = ctrl1[afe_ctl_pkg::C1_DIR_LSB +: 4] & ~(hooksrc_s ? 4'h6 : 4'h0);
        next_drive.val = ctrl2[afe_ctl_pkg::C2_OUT_LSB +: 4];
        if (ctrl2[afe_ctl_pkg::C2_GP0CLK_BIT]) next_drive.val[0] = div_clk;
        if (ctrl2[afe_ctl_pkg::C2_GP3CLK_BIT]) next_drive.val[3] = carrier_s;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_pin_o    <= 4'h0;
            port_pin_oe_o <= 4'h0;
        end else begin
            port_pin_o    <= next_drive.val;
            port_pin_oe_o <= next_drive.oe;
        end
    end

    // frame sync: master divider or slave falling-edge detect
    always_comb begin
        period = over_of(ctrl0[afe_ctl_pkg::C0_OVER_LSB +: 3]);
        if (divsel_s) begin
            period = 13'(period
                     * (ctrl0[afe_ctl_pkg::C0_M_BIT] ? afe_ctl_pkg::M_HI : afe_ctl_pkg::M_LO)
                     * (ctrl0[afe_ctl_pkg::C0_Q_BIT] ? afe_ctl_pkg::Q_HI : afe_ctl_pkg::Q_LO));
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fs_cnt          <= 13'h0;
            fs_in_q         <= 1'b0;
            frame_sync_o    <= 1'b0;
            frame_sync_oe_o <= 1'b0;
            frame_start_o   <= 1'b0;
        end else begin
            fs_in_q         <= fs_in_s;
            frame_sync_oe_o <= master_s;
            frame_sync_o    <= 1'b0;
            frame_start_o   <= 1'b0;
            if (!serial_port_on_o) begin
                fs_cnt <= 13'h0;
            end else if (master_s) begin
                if (fs_cnt >= period - 13'h1) begin
                    fs_cnt        <= 13'h0;
                    frame_sync_o  <= 1'b1;
                    frame_start_o <= 1'b1;
                end else begin
                    fs_cnt <= fs_cnt + 13'h1;
                end
            end else begin
                frame_start_o <= fs_in_q && !fs_in_s;
            end
        end
    end

    // timeslot choice
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slot_second_o    <= 1'b0;
            slot_first_bit_o <= 6'h0;
        end else begin
            slot_second_o    <= ts_s;
            slot_first_bit_o <= ts_s ? afe_ctl_pkg::SLOT_BITS : 6'h0;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_fs_reload: assert property (serial_port_on_o && master_s && fs_cnt >= period - 13'h1
        |=> frame_sync_o && fs_cnt == 13'h0) else $error("frame sync missed reload");
    a_fs_slave_in: assert property (!master_s |=> !frame_sync_oe_o && !frame_sync_o)
        else $error("slave drives frame sync");
    a_slot_pick: assert property (##1 slot_first_bit_o == ($past(ts_s) ? 6'h10 : 6'h0))
        else $error("wrong timeslot");
    a_dir_input: assert property (ctrl1[3:0] == 4'h0 |=> port_pin_oe_o == 4'h0)
        else $error("pin driven while input");
    a_hook_pins_in: assert property (hooksrc_s |=> !port_pin_oe_o[1] && !port_pin_oe_o[2])
        else $error("hook pins driven");
    a_irq_toggle: assert property (evt |=> general_interrupt_out_o != $past(general_interrupt_out_o))
        else $error("interrupt missed toggle");
    a_irq_quiet: assert property (!evt |=> $stable(general_interrupt_out_o))
        else $error("spurious interrupt toggle");
    a_mode0_dark: assert property (state == PW_SLEEP |=> !serial_port_on_o && !core_active_o)
        else $error("serial port on while asleep");
    a_wake_serial: assert property (state == PW_SLEEP && mode1 && evt && !sleep_s
        |=> ##1 serial_port_on_o) else $error("no wake on event");
    a_read_resleep: assert property (state == PW_WAKE && rd2 && !sleep_s
        |=> ##1 !serial_port_on_o) else $error("serial port left on");
    a_resume_wait: assert property (state == PW_RESUME && sleep_s
        && resume_cnt != ($bits(resume_cnt))'(RESUME_CYCLES - 1)
        |=> !core_active_o) else $error("resumed early");

    c_master_fs: cover property (master_s && frame_sync_o);
    c_wake_read: cover property (state == PW_WAKE ##[1:50] state == PW_SLEEP);
    c_resume: cover property (state == PW_RESUME ##1 state == PW_RUN);
endmodule
`default_nettype wire

// ===== sim/afe_host_model.sv
/*
 * host side model: supplies slave frame sync and the carrier clock.
 * assumes clk_i is the bench clock and slave_en_i a bench level.
 */
`timescale 1ns/1ps
`default_nettype none
module afe_host_model (
    // clock
    input  wire logic clk_i,
    // control
    input  wire logic slave_en_i,
    // outputs
    output logic      frame_sync_o,
    output logic      carrier_o
);
    logic [7:0] cnt = 8'h00;
    initial begin
        frame_sync_o = 1'b1;
        carrier_o = 1'b0;
    end
    always @(posedge clk_i) begin
        cnt <= cnt + 8'h01;
        // period of 8 clocks keeps the carrier well under clk/4
        carrier_o <= cnt[2];
        // one low clock every 64 when slave; idles high otherwise so no false edge
        frame_sync_o <= slave_en_i ? (cnt[5:0] != 6'h00) : 1'b1;
    end
endmodule
`default_nettype wire

// ===== sim/test_afe_gpio_clock_power_control.sv
/*
 * self-checking bench for the pin, clock and power control block.
 * assumes the host model supplies carrier and slave frame sync.
 */
`timescale 1ns/1ps
`default_nettype none
module test_afe_gpio_clock_power_control;
    logic       clk_i, rst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic       pready, pslverr, car, fsi, fso, fsoe, fst, s2, ring, irq, spon, core;
    logic       cds = 1'b0, ms = 1'b1, ts = 1'b0, hs = 1'b0, sl_n = 1'b1, rs = 1'b0;
    logic       liu = 1'b0, ll = 1'b0, slave_en = 1'b0, irq_exp = 1'b0, errv, p0, p3;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic [3:0] pdrv = 4'h0, pout, poe;
    wire  [3:0] pin = (poe & pout) | (~poe & pdrv);
    logic [5:0] sbit;
    afe_ctl_pkg::hook_ctl_t hook;
    int         err_total = 0, total_checks = 0, n0, n3, k;

    afe_gpio_clock_power_control #(.RESUME_CYCLES(20)) dut (
        .clk_i, .rst_n_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .clock_divider_select_i(cds), .master_select_i(ms),
        .timeslot_select_i(ts), .hook_control_source_i(hs), .sleep_n_i(sl_n),
        .carrier_clock_i(car), .ring_sense_i(rs), .line_in_use_i(liu), .loop_limit_i(ll),
        .port_pin_i(pin), .port_pin_o(pout), .port_pin_oe_o(poe), .frame_sync_i(fsi),
        .frame_sync_o(fso), .frame_sync_oe_o(fsoe), .frame_start_o(fst),
        .slot_second_o(s2), .slot_first_bit_o(sbit), .ring_o(ring),
        .general_interrupt_out_o(irq), .serial_port_on_o(spon), .core_active_o(core),
        .hook_o(hook)
    );
    afe_host_model host (.clk_i, .slave_en_i(slave_en), .frame_sync_o(fsi), .carrier_o(car));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task complete_run;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // apb master: setup, access held until pready, release after the sampling edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 16);
        chk(pready, 1'b1, "pready");
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // outputs are looked at on falling edges, where they are settled
    task settle(input int c);
        repeat (c) @(negedge clk_i);
    endtask

    task fsp(input int e);
        int t0;
        k = 0;
        for (int i = 0; i < 3; i++) begin
            do begin
                @(negedge clk_i);
                k++;
            end while (fso !== 1'b1 && k < 5000);
            if (i == 1)
                t0 = k;
        end
        chk(k - t0, e, "frame period");
    endtask

    initial begin
        #500000;
        err_total++;
        complete_run();
    end

    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        settle(2);
        chk(poe, 4'h0, "oe after reset");
        chk(sbit, 6'h00, "slot bit");
        apb(1'b0, 8'h00, 32'h0);
        chk(rdv, 32'h0300, "ctrl0 reset");
        apb(1'b0, 8'h04, 32'h0);
        chk(rdv, 32'h0, "ctrl1 reset");
        apb(1'b0, 8'h20, 32'h0);
        chk({rdv[30:0], errv}, 32'h1, "unmapped");
        apb(1'b1, 8'h04, 32'h0e9);
        apb(1'b1, 8'h08, 32'h009);
        pdrv <= 4'h6;
        settle(6);
        chk({poe, pout}, 8'h99, "dir and out");
        chk(irq, irq_exp, "masked pins");
        apb(1'b0, 8'h08, 32'h0);
        chk(rdv[3:0], 4'hf, "pin levels");
        apb(1'b1, 8'h04, 32'h0a9);
        pdrv <= 4'h2;
        settle(6);
        irq_exp = ~irq_exp;
        chk(irq, irq_exp, "pin irq");
        settle(6);
        chk(irq, irq_exp, "one toggle");
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i);
            {ll, liu, rs} <= 3'b001 << i;
            settle(6);
            irq_exp = ~irq_exp;
            chk({ring, irq}, {1'b1, irq_exp}, "ring on");
            @(posedge clk_i);
            {ll, liu, rs} <= 3'b000;
            settle(6);
            irq_exp = ~irq_exp;
            chk({ring, irq}, {1'b0, irq_exp}, "ring off");
        end
        apb(1'b1, 8'h04, 32'h0f9);
        hs <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            @(posedge clk_i);
            pdrv[2:1] <= {c[0], c[1]};
            settle(6);
            chk(hook, (c == 3) ? 2'b10 : c[1:0], "hook pins");
        end
        @(posedge clk_i);
        hs <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, 8'h0c, {28'h0, c[0], c[1], 2'b00});
            settle(6);
            chk(hook, (c == 3) ? 2'b10 : c[1:0], "hook bits");
        end
        apb(1'b1, 8'h08, 32'h1440);
        settle(2);
        {n0, n3, p0, p3} = {32'd0, 32'd0, pout[0], pout[3]};
        for (int i = 0; i < 160; i++) begin
            @(negedge clk_i);
            n0 += int'(pout[0] !== p0);
            n3 += int'(pout[3] !== p3);
            {p0, p3} = {pout[0], pout[3]};
        end
        chk(n3 > 30 && n0 > 10 && n0 < n3, 1'b1, "carrier out");
        apb(1'b1, 8'h08, 32'h009);
        settle(4);
        chk(pout, 4'h9, "static out");
        apb(1'b1, 8'h00, 32'h028);
        fsp(128);
        chk(fsoe, 1'b1, "fs drive");
        @(posedge clk_i);
        cds <= 1'b1;
        fsp(384);
        @(posedge clk_i);
        {ms, slave_en, ts} <= 3'b011;
        k = 0;
        do begin
            @(negedge clk_i);
            k++;
        end while (fst !== 1'b1 && k < 200);
        chk({fst, fsoe, s2, sbit}, {3'b101, 6'h10}, "slave frame");
        apb(1'b1, 8'h04, 32'h1f0);
        apb(1'b1, 8'h0c, 32'h000);
        pdrv <= 4'h0;
        sl_n <= 1'b0;
        rs <= 1'b1;
        settle(8);
        chk({spon, core, ring}, 3'b000, "sleep mode 0");
        @(posedge clk_i);
        {sl_n, rs} <= 2'b10;
        settle(10);
        chk(core, 1'b0, "resume wait");
        settle(20);
        chk(core, 1'b1, "resumed");
        apb(1'b1, 8'h0c, 32'h010);
        sl_n <= 1'b0;
        settle(8);
        @(posedge clk_i);
        rs <= 1'b1;
        settle(8);
        chk({ring, spon, irq}, {2'b10, irq_exp}, "sleep masked");
        @(posedge clk_i);
        {sl_n, rs} <= 2'b10;
        settle(30);
        chk(spon, 1'b1, "serial back");
        apb(1'b1, 8'h04, 32'h000);
        sl_n <= 1'b0;
        settle(8);
        @(posedge clk_i);
        pdrv[0] <= 1'b1;
        settle(6);
        irq_exp = ~irq_exp;
        chk({spon, irq}, {1'b1, irq_exp}, "wake");
        apb(1'b0, 8'h08, 32'h0);
        chk(rdv[0], 1'b1, "wake pins");
        settle(4);
        chk(spon, 1'b0, "serial off");
        @(posedge clk_i);
        sl_n <= 1'b1;
        settle(30);
        apb(1'b0, 8'h0c, 32'h0);
        chk({core, rdv}, {1'b1, 32'h10}, "state kept");
        complete_run();
    end
endmodule
`default_nettype wire
